// [verilog/spi_eeprom_consts.vh]
// Constants for the serial EEPROM command logic.
// Assumes a single system clock domain; serial pins are sampled asynchronously.
`ifndef SPI_EEPROM_CONSTS_VH
`define SPI_EEPROM_CONSTS_VH
`define OP_SET_WEL 8'h06
`define OP_CLR_WEL 8'h04
`define OP_RD_STAT 8'h05
`define OP_WR_STAT 8'h01
`define OP_RD_ARR 8'h03
`define OP_WR_ARR 8'h02
`define OP_RD_ID 8'h83
`define OP_WR_ID 8'h82
`define OP_MASK 8'hf7
`define ADDR_W 14
`define ARR_DEPTH 16384
`define PAGE_W 6
`define PAGE_BYTES 64
`define ID_SEL_BIT 10
`define STAT_BP_LO 2
`define STAT_BP_HI 3
`define STAT_PPE 7
`define STAT_WEL 1
`define STAT_BUSY 0
`define WRITE_TIME_NS 5000
`define CLK_PERIOD_NS 25
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// [verilog/byte_fifo.v]
// Parameterised synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Fill side.
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ff;
    reg [AW:0] rd_ff;
    wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    wire empty = (wr_ff == rd_ff);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ff[AW-1:0]];
    // Pointers carry one extra bit so full and empty are told apart honestly.
    always @(posedge clk) begin
        if (!rst_n) begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wr_ff[AW-1:0]] <= in_data;
                wr_ff <= wr_ff + 1'b1;
            end
            if (out_ready && !empty)
                rd_ff <= rd_ff + 1'b1;
        end
    end
endmodule // byte_fifo

// [verilog/spi_eeprom_command_logic.v]
// Serial command logic of a 16K x 8 EEPROM slave, with array and ID page storage.
// Assumes clk runs much faster than the serial clock so pin edges can be sampled.
// Overview of operation
// - Sample input on rising edges, MSB first.
// - Shift output on falling edges, MSB first.
// - Return to standby after operation completes.
// - Opcode 06 sets the write latch.
// - Opcode 04 clears the write latch.
// - Opcode 05 repeats the status byte.
// - Busy device accepts only status read.
// - Status write stores protect bits only.
// - Status write needs latch, no hardware protect.
// - Status bits change only at cycle end.
// - Pin-enable falls only while pin high.
// - Latch cleared at reset and after writes.
// - Array read streams and wraps to zero.
// - Page write wraps low six bits.
// - Over 64 bytes keeps final sixty-four.
// - Protected block never written; latch required.
// - ID read starts at low six bits.
// - ID read rejected while busy.
// - ID write fills the identification page.
// - Address bit ten selects lock commands.
// - Status reads all ones while busy.
// - Protect bits select upper array ranges.
// - Hardware protect needs pin low, enable set.
// - Lock status byte carries lock bit.
`include "spi_eeprom_consts.vh"
module spi_eeprom_command_logic #(
    parameter WRITE_CYCLES = `WRITE_CYCLES
) (
    // System clock and reset.
    input wire clk,
    input wire rst_n,
    // Serial pins.
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    output wire so,
    output wire so_oe_n,
    // Status view for the system.
    output wire busy,
    output wire fifo_stall
);
    localparam ST_IDLE = 3'd0;
    localparam ST_OPC = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_OUT = 3'd4;
    localparam ST_SKIP = 3'd5;
    // Latch commands park here so a stray extra byte cannot replace the opcode.
    localparam ST_DONE = 3'd6;

    // Array, ID page and its page buffer.
    reg [7:0] arr [0:`ARR_DEPTH-1];
    reg [7:0] idp [0:`PAGE_BYTES-1];
    reg [7:0] pbuf [0:`PAGE_BYTES-1];
    reg [`PAGE_BYTES-1:0] pval_ff;

    // Two-flop synchronisers, then an edge history stage.
    reg [1:0] cs_s_ff, sck_s_ff, si_s_ff, wp_s_ff;
    reg sck_d_ff, cs_d_ff;
    always @(posedge clk) begin
        if (!rst_n) begin
            cs_s_ff <= 2'b11;
            sck_s_ff <= 2'b00;
            si_s_ff <= 2'b00;
            wp_s_ff <= 2'b11;
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            cs_s_ff <= {cs_s_ff[0], cs_n};
            sck_s_ff <= {sck_s_ff[0], sck};
            si_s_ff <= {si_s_ff[0], si};
            wp_s_ff <= {wp_s_ff[0], wp_n};
            sck_d_ff <= sck_s_ff[1];
            cs_d_ff <= cs_s_ff[1];
        end
    end
    wire cs_lo = !cs_s_ff[1];
    wire sck_rise = cs_lo && sck_s_ff[1] && !sck_d_ff;
    wire sck_fall = cs_lo && !sck_s_ff[1] && sck_d_ff;
    wire cs_rise = cs_s_ff[1] && !cs_d_ff;
    wire cs_fall = !cs_s_ff[1] && cs_d_ff;

    // Opcode class decoder used for launch and dispatch.
    function [2:0] op_class;
        input [7:0] op;
        begin
            case (op & `OP_MASK)
                `OP_SET_WEL: op_class = 3'd1;
                `OP_CLR_WEL: op_class = 3'd2;
                `OP_RD_STAT: op_class = 3'd3;
                `OP_WR_STAT: op_class = 3'd4;
                `OP_RD_ARR: op_class = 3'd5;
                `OP_WR_ARR: op_class = 3'd6;
                `OP_RD_ID: op_class = 3'd7;
                `OP_WR_ID: op_class = 3'd0;
                default: op_class = 3'd0;
            endcase
        end
    endfunction

    // Protected range check for an array address.
    function in_block;
        input [1:0] bp;
        input [`ADDR_W-1:0] a;
        begin
            case (bp)
                2'b01: in_block = (a[13:12] == 2'b11);
                2'b10: in_block = a[13];
                2'b11: in_block = 1'b1;
                default: in_block = 1'b0;
            endcase
        end
    endfunction

    reg [2:0] st_ff;
    reg [7:0] sh_ff;
    reg [2:0] bit_ff;
    reg [7:0] op_ff;
    reg id_op_ff;
    reg [15:0] addr_ff;
    reg addr_byte_ff;
    reg [7:0] tx_ff;
    reg so_ff;
    reg oe_n_ff;
    reg got_data_ff;
    reg [7:0] wsr_ff;
    reg wel_ff, bp_lo_ff, bp_hi_ff, ppe_ff, lock_ff;
    reg [15:0] wcnt_ff;
    reg [1:0] wkind_ff;
    reg [`ADDR_W-1:0] wbase_ff;
    wire hw_prot = !wp_s_ff[1] && ppe_ff;
    assign busy = (wcnt_ff != 16'h0000);
    wire [7:0] stat_byte = busy ? 8'hff :
        {ppe_ff, 3'b000, bp_hi_ff, bp_lo_ff, wel_ff, 1'b0};
    wire [2:0] cls = op_class(op_ff);
    wire is_wr_id = ((op_ff & `OP_MASK) == `OP_WR_ID);
    wire lock_sel = addr_ff[`ID_SEL_BIT];
    wire [7:0] rx_byte = {sh_ff[6:0], si_s_ff[1]};

    // Received data bytes pass through the FIFO before landing in the page buffer.
    wire f_in_ready, f_out_valid;
    wire [7:0] f_out_data;
    reg [`PAGE_W-1:0] f_pos_ff [0:`FIFO_DEPTH-1];
    reg [`FIFO_AW-1:0] fpw_ff, fpr_ff;
    wire drain = f_out_valid && !busy;
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(sck_rise && st_ff == ST_DATA && bit_ff == 3'd7 && f_in_ready),
        .in_ready(f_in_ready),
        .in_data(rx_byte),
        .out_valid(f_out_valid),
        .out_ready(drain),
        .out_data(f_out_data)
    );
    // A full FIFO drops bytes, so the stall flag warns a too-fast master.
    assign fifo_stall = !f_in_ready;

    assign so = so_ff;
    assign so_oe_n = oe_n_ff;

    // Launch decision at deselect.
    wire launch_ok = got_data_ff && !busy && !f_out_valid;

    // Command sequencer, storage and write cycle timer.
    always @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            sh_ff <= 8'h00;
            bit_ff <= 3'd0;
            op_ff <= 8'h00;
            id_op_ff <= 1'b0;
            addr_ff <= 16'h0000;
            addr_byte_ff <= 1'b0;
            tx_ff <= 8'h00;
            so_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            got_data_ff <= 1'b0;
            wsr_ff <= 8'h00;
            wel_ff <= 1'b0;
            bp_lo_ff <= 1'b0;
            bp_hi_ff <= 1'b0;
            ppe_ff <= 1'b0;
            lock_ff <= 1'b0;
            wcnt_ff <= 16'h0000;
            wkind_ff <= 2'd0;
            wbase_ff <= {`ADDR_W{1'b0}};
            pval_ff <= {`PAGE_BYTES{1'b0}};
            fpw_ff <= {`FIFO_AW{1'b0}};
            fpr_ff <= {`FIFO_AW{1'b0}};
        end else begin
            // Drained bytes land at their wrapped page slot; later ones overwrite.
            if (drain) begin
                pbuf[f_pos_ff[fpr_ff]] <= f_out_data;
                pval_ff[f_pos_ff[fpr_ff]] <= 1'b1;
                fpr_ff <= fpr_ff + 1'b1;
            end
            // Self-timed write completes and commits its effect.
            if (busy) begin
                wcnt_ff <= wcnt_ff - 1'b1;
                if (wcnt_ff == 16'h0001) begin
                    wel_ff <= 1'b0;
                    pval_ff <= {`PAGE_BYTES{1'b0}};
                    if (wkind_ff == 2'd0) begin
                        bp_lo_ff <= wsr_ff[`STAT_BP_LO];
                        bp_hi_ff <= wsr_ff[`STAT_BP_HI];
                        if (wsr_ff[`STAT_PPE] || wp_s_ff[1])
                            ppe_ff <= wsr_ff[`STAT_PPE];
                    end else if (wkind_ff == 2'd3) begin
                        lock_ff <= 1'b1;
                    end
                end
            end
            if (cs_fall) begin
                st_ff <= ST_OPC;
                bit_ff <= 3'd0;
                addr_byte_ff <= 1'b0;
                got_data_ff <= 1'b0;
                pval_ff <= busy ? pval_ff : {`PAGE_BYTES{1'b0}};
            end
            if (cs_rise) begin
                st_ff <= ST_IDLE;
                oe_n_ff <= 1'b1;
                if (st_ff == ST_DONE && bit_ff == 3'd0 && !busy) begin
                    if (cls == 3'd1)
                        wel_ff <= 1'b1;
                    if (cls == 3'd2)
                        wel_ff <= 1'b0;
                end
                // Launch only on a clean byte boundary.
                if (bit_ff == 3'd0 && launch_ok && wel_ff) begin
                    if (cls == 3'd4 && !hw_prot) begin
                        wkind_ff <= 2'd0;
                        wcnt_ff <= WRITE_CYCLES[15:0];
                    end else if (cls == 3'd6 || (is_wr_id && !lock_ff)) begin
                        wkind_ff <= is_wr_id ? (lock_sel ? 2'd3 : 2'd2) : 2'd1;
                        if (!(is_wr_id && lock_sel && (bp_lo_ff & bp_hi_ff)))
                            wcnt_ff <= WRITE_CYCLES[15:0];
                    end
                end
            end else if (sck_rise) begin
                sh_ff <= rx_byte;
                bit_ff <= bit_ff + 1'b1;
                if (bit_ff == 3'd7) begin
                    case (st_ff)
                        ST_OPC: begin
                            op_ff <= rx_byte;
                            id_op_ff <= rx_byte[7];
                            if (busy && op_class(rx_byte) != 3'd3) begin
                                st_ff <= ST_SKIP;
                            end else begin
                                case (op_class(rx_byte))
                                    3'd1, 3'd2: st_ff <= ST_DONE;
                                    3'd3: begin
                                        st_ff <= ST_OUT;
                                        tx_ff <= stat_byte;
                                    end
                                    3'd4: st_ff <= ST_DATA;
                                    3'd5, 3'd6, 3'd7: st_ff <= ST_ADDR;
                                    3'd0: st_ff <= ((rx_byte & `OP_MASK) == `OP_WR_ID) ?
                                        ST_ADDR : ST_SKIP;
                                    default: st_ff <= ST_SKIP;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            addr_ff <= {addr_ff[7:0], rx_byte};
                            addr_byte_ff <= 1'b1;
                            if (addr_byte_ff) begin
                                if (cls == 3'd6 || is_wr_id) begin
                                    st_ff <= ST_DATA;
                                end else begin
                                    st_ff <= ST_OUT;
                                    // The high address byte still sits in the low half of addr_ff.
                                    if (cls == 3'd7 && addr_ff[`ID_SEL_BIT-8]) begin
                                        tx_ff <= {7'b0000000, lock_ff};
                                    end else if (cls == 3'd7) begin
                                        tx_ff <= idp[rx_byte[`PAGE_W-1:0]];
                                    end else begin
                                        tx_ff <= arr[{addr_ff[5:0], rx_byte}];
                                    end
                                end
                                wbase_ff <= {addr_ff[5:0], rx_byte};
                            end
                        end
                        ST_DATA: begin
                            got_data_ff <= 1'b1;
                            if (cls == 3'd4)
                                wsr_ff <= rx_byte & 8'h8c;
                            f_pos_ff[fpw_ff] <= wbase_ff[`PAGE_W-1:0];
                            if (f_in_ready)
                                fpw_ff <= fpw_ff + 1'b1;
                            wbase_ff[`PAGE_W-1:0] <= wbase_ff[`PAGE_W-1:0] + 1'b1;
                        end
                        default: ;
                    endcase
                end
                if (bit_ff == 3'd7 && st_ff == ST_OUT) begin
                    // Next byte is fetched ahead of its first falling edge.
                    if (cls == 3'd3)
                        tx_ff <= stat_byte;
                    else if (cls == 3'd7 && lock_sel)
                        tx_ff <= {7'b0000000, lock_ff};
                    else if (cls == 3'd7)
                        tx_ff <= idp[addr_ff[`PAGE_W-1:0] + 1'b1];
                    else
                        tx_ff <= arr[addr_ff[`ADDR_W-1:0] + 1'b1];
                    addr_ff <= addr_ff + 1'b1;
                end
            end else if (sck_fall && st_ff == ST_OUT) begin
                oe_n_ff <= 1'b0;
                so_ff <= tx_ff[3'd7 - bit_ff];
            end
            if (cls == 3'd7 && busy && st_ff == ST_OUT)
                st_ff <= ST_SKIP;
        end
    end

    // Commit the page buffer on the last cycle of the write; protected bytes are skipped.
    genvar g;
    generate
        for (g = 0; g < `PAGE_BYTES; g = g + 1) begin : g_commit
            wire [`ADDR_W-1:0] a = {wbase_ff[`ADDR_W-1:`PAGE_W], g[`PAGE_W-1:0]};
            always @(posedge clk) begin
                if (rst_n && wcnt_ff == 16'h0001 && pval_ff[g]) begin
                    if (wkind_ff == 2'd1 && !in_block({bp_hi_ff, bp_lo_ff}, a))
                        arr[a] <= pbuf[g];
                    if (wkind_ff == 2'd2)
                        idp[g] <= pbuf[g];
                end
            end
        end
    endgenerate
endmodule // spi_eeprom_command_logic

// [testbench/spi_eeprom_props.sv]
// Checker for the serial EEPROM command logic, watching only its top-level pins.
// Assumes clk is the one clock and rst_n a synchronous active-low reset.
module spi_eeprom_props #(
    parameter WRITE_CYCLES = 200
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Serial pins.
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    input wire so,
    input wire so_oe_n,
    // Status.
    input wire busy,
    input wire fifo_stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    localparam int LO = WRITE_CYCLES - 2;
    localparam int HI = WRITE_CYCLES + 1;
    int busy_len;
    // Length of the running write cycle; a slack of a cycle or two allows for the sync delay.
    always @(posedge clk) begin
        if (!rst_n || !busy) busy_len <= 0;
        else busy_len <= busy_len + 1;
    end
    sequence desel_s;
        cs_n [*6];
    endsequence
    sequence ended_s;
        $fell(busy) && $past(rst_n);
    endsequence
    idle_release_a: assert property (desel_s |-> so_oe_n)
        else $error("so_oe_n low after deselect");
    drive_sel_a: assert property ($fell(so_oe_n) |-> !cs_n)
        else $error("so_oe_n fell while deselected");
    busy_launch_a: assert property ($rose(busy) |-> $past(cs_n, 2))
        else $error("write cycle started while selected");
    len_low_a: assert property (ended_s |-> busy_len >= LO)
        else $error("write cycle too short");
    len_high_a: assert property (busy |-> busy_len <= HI)
        else $error("write cycle too long");
    so_shift_a: assert property (!so_oe_n && $past(!so_oe_n) && $changed(so) |-> !$past(sck, 2))
        else $error("so changed outside a low sck phase");
    busy_ones_a: assert property (busy && !so_oe_n && $past(busy, 4) |-> so)
        else $error("status bit low during write cycle");
    reset_out_a: assert property ($rose(rst_n) |-> so_oe_n && so && !busy)
        else $error("outputs not in standby after reset");
endmodule // spi_eeprom_props

bind spi_eeprom_command_logic spi_eeprom_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_spi_eeprom_props (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .busy(busy), .fifo_stall(fifo_stall));

// [testbench/spi_master_model.sv]
// Mode 0 serial master model that frames bytes on the serial pins.
// Assumes the bench clock clk; pins change at its falling edge.
module spi_master_model (
    // Bench clock.
    input wire clk,
    // Serial pins.
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire so
);
    timeunit 1ns;
    timeprecision 100ps;
    // Deselected, clock idle low; the clock stands still outside frames.
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Select, then give the device's synchroniser time to see it.
    task automatic start();
        @(negedge clk) cs_n = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Four clocks a half period gives the 200 ns serial clock; so is read before the rise.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            repeat (4) @(negedge clk);
            rx[i] = so;
            sck = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask
    // Deselect before any further rising edge; the released data line shows the inverse.
    task automatic stop();
        cs_n = 1'b1;
        @(negedge clk);
        sck = 1'b0;
        si = ~si;
        repeat (8) @(negedge clk);
    endtask
endmodule // spi_master_model

// [testbench/tb_spi_eeprom_command_logic.sv]
// Self-checking bench for the serial EEPROM command logic.
// Assumes the master model for framing and the constants header for opcodes.
`include "spi_eeprom_consts.vh"
module tb_spi_eeprom_command_logic;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WC = 300;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic oe_seen = 1'b0;
    logic cs_n, sck, si;
    wire so, so_oe_n, busy, fifo_stall;
    logic [7:0] rx, st;
    int n_mismatch = 0;
    int checks = 0;
    // 40 MHz bench clock.
    always #12.5 clk = ~clk;
    // Notes any drive of so, to prove a frame was refused.
    always @(posedge clk) if (so_oe_n === 1'b0) oe_seen <= 1'b1;
    spi_eeprom_command_logic #(.WRITE_CYCLES(WC)) i_spi_eeprom_command_logic (
        .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe_n(so_oe_n), .busy(busy), .fifo_stall(fifo_stall));
    spi_master_model i_spi_master_model (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic x(input logic [7:0] t);
        i_spi_master_model.xfer(t, rx);
    endtask
    task automatic stop();
        i_spi_master_model.stop();
    endtask
    task automatic head(input logic [7:0] op, input logic [15:0] a);
        i_spi_master_model.start();
        x(op);
        x(a[15:8]);
        x(a[7:0]);
    endtask
    task automatic cmd(input logic [7:0] op);
        i_spi_master_model.start();
        x(op);
        stop();
    endtask
    // Two status bytes in one frame; the second must repeat the first.
    task automatic rd_st();
        logic [7:0] first;
        i_spi_master_model.start();
        x(`OP_RD_STAT);
        x(8'h00);
        first = rx;
        x(8'h00);
        stop();
        chk("status repeat", rx, first);
        st = rx;
    endtask
    task automatic settle();
        for (int i = 0; i < 2 * WC && busy !== 1'b0; i++) @(negedge clk);
    endtask
    // A launched write must be running now and must end within a bounded wait.
    task automatic idle();
        chk("busy", {7'h0, busy}, 8'h01);
        settle();
        chk("idle", {7'h0, busy}, 8'h00);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cmd(`OP_SET_WEL);
        head(`OP_WR_ARR, a);
        x(d);
        stop();
    endtask
    task automatic rd(input logic [15:0] a);
        head(`OP_RD_ARR, a);
        x(8'h00);
    endtask
    task automatic status_write_cmd(input logic [7:0] d);
        cmd(`OP_SET_WEL);
        i_spi_master_model.start();
        x(`OP_WR_STAT);
        x(d);
        stop();
    endtask
    task automatic t_latch();
        rd_st();
        chk("status reset", st, 8'h00);
        cmd(`OP_SET_WEL);
        rd_st();
        chk("latch set", st, 8'h02);
        cmd(`OP_CLR_WEL);
        rd_st();
        chk("latch clear", st, 8'h00);
    endtask
    // Page wrap at the top page, array wrap to zero, upper address bits, overrun.
    task automatic t_array();
        cmd(`OP_SET_WEL);
        head(`OP_WR_ARR, 16'h3fff);
        x(8'ha1);
        x(8'hb2);
        stop();
        cmd(`OP_SET_WEL);
        idle();
        rd_st();
        chk("latch after write", st, 8'h00);
        wr(16'hc000, 8'hc3);
        idle();
        head(`OP_WR_ARR, 16'h0000);
        x(8'h5a);
        stop();
        chk("no latch", {7'h0, busy}, 8'h00);
        rd(16'h3fff);
        chk("last", rx, 8'ha1);
        x(8'h00);
        chk("wrap", rx, 8'hc3);
        stop();
        rd(16'h3fc0);
        chk("page wrap", rx, 8'hb2);
        stop();
        cmd(`OP_SET_WEL);
        head(`OP_WR_ARR, 16'h0100);
        for (int i = 0; i < 65; i++) x(i[7:0]);
        chk("no stall", {7'h0, fifo_stall}, 8'h00);
        stop();
        idle();
        rd(16'h0100);
        chk("overrun", rx, 8'h40);
        x(8'h00);
        chk("kept", rx, 8'h01);
        stop();
    endtask
    task automatic t_status();
        status_write_cmd(8'hff);
        rd_st();
        chk("busy status", st, 8'hff);
        idle();
        rd_st();
        chk("stored bits", st, 8'h8c);
        wp_n = 1'b0;
        status_write_cmd(8'h00);
        chk("hw protect", {7'h0, busy}, 8'h00);
        rd_st();
        chk("enable kept", st & 8'h8c, 8'h8c);
        cmd(`OP_CLR_WEL);
        wp_n = 1'b1;
        status_write_cmd(8'h04);
        idle();
        rd_st();
        chk("quarter", st, 8'h04);
        wr(16'h3fff, 8'h77);
        settle();
        rd(16'h3fff);
        chk("protected", rx, 8'ha1);
        stop();
        wr(16'h2fff, 8'h66);
        idle();
        rd(16'h2fff);
        chk("outside block", rx, 8'h66);
        stop();
        status_write_cmd(8'h00);
        idle();
    endtask
    task automatic t_id();
        cmd(`OP_SET_WEL);
        head(`OP_WR_ID, 16'hf805);
        x(8'hd1);
        x(8'hd2);
        stop();
        idle();
        head(`OP_RD_ID, 16'hf8c5);
        x(8'h00);
        chk("id first", rx, 8'hd1);
        x(8'h00);
        chk("id next", rx, 8'hd2);
        stop();
        head(`OP_RD_ID, 16'h0400);
        x(8'h00);
        chk("lock bit", {7'h0, rx[0]}, 8'h00);
        stop();
        wr(16'h0200, 8'h11);
        oe_seen = 1'b0;
        head(`OP_RD_ID, 16'hf805);
        x(8'h00);
        stop();
        chk("busy id read", {7'h0, oe_seen}, 8'h00);
        settle();
        oe_seen = 1'b0;
        head(8'h55, 16'h0000);
        x(8'h00);
        stop();
        chk("unknown op", {7'h0, oe_seen}, 8'h00);
        rd_st();
        chk("state kept", st, 8'h00);
    endtask
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_latch();
        t_array();
        t_status();
        t_id();
        results();
    end
    // The scenarios need some 15000 cycles; over twice that means a hang.
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule // tb_spi_eeprom_command_logic
